/* common/ldc_params.svh */
// Constants shared by both ends of the display port link.
// Assumes core_clk at 40 MHz; times are kept in their own unit.
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LDC_CLK_NS       25
`define LDC_CLR_TIME_NS  110000
`define LDC_CLR_TICKS    3
`define LDC_RST_TICKS    3
// One display clock tick, least time rounded up to core cycles
`define LDC_TICK_CYC ((`LDC_CLR_TIME_NS + `LDC_CLR_TICKS * `LDC_CLK_NS - 1) / (`LDC_CLR_TICKS * `LDC_CLK_NS))
`define LDC_TEST_TICKS   262144
`define LDC_PAT_HOLD_MS  2000
`define LDC_TEST_TYP_MS  4600
`define LDC_PAT_TICKS (`LDC_TEST_TICKS * `LDC_PAT_HOLD_MS / `LDC_TEST_TYP_MS)
`define LDC_BLINK_DIV    28672
// Host bus cycle shape, core cycles
`define LDC_SETUP_CYC    2
`define LDC_STROBE_CYC   8
`define LDC_HOLD_CYC     4
`define LDC_RST_LOW_CYC  4
`define LDC_MARGIN_CYC   16
// ---------------------------------------------------------------
// Control word fields and reset values
// ---------------------------------------------------------------
`define LDC_CW_CLEAR     7
`define LDC_CW_TEST      6
`define LDC_CW_PASS      5
`define LDC_CW_BLINK     4
`define LDC_CW_FLASH     3
`define LDC_CW_RESET     8'h00
`define LDC_BLANK_LEVEL  3'h7
`define LDC_BLANK_CODE   8'h20
`define LDC_GLYPH_END    4'hf
`define LDC_PIN_IDLE     18'h3ffff
`endif

/* common/ldc_pkg.sv */
// Types shared by both ends of the display port link.
// Assumes ldc_params.svh for all numeric constants.
package ldc_pkg;
  // Device sequencer
  typedef enum logic [1:0] {DEV_RESET, DEV_IDLE, DEV_CLEAR, DEV_TEST}
    ldc_dev_state_t;
  // Host bus sequencer
  typedef enum logic [2:0] {H_RST, H_WAIT, H_IDLE, H_SETUP, H_STROBE,
                            H_HOLD} ldc_host_state_t;
endpackage : ldc_pkg

/* common/ldc_bus_if.sv */
// Parallel pin bundle between host and display device.
// Assumes both ends on core_clk; data wire resolved here from enables.
interface ldc_bus_if;
  logic       ce_n;
  logic       wr_n;
  logic       rd_n;
  logic       blink_mem_select_n;
  logic [4:0] addr;
  logic       disp_rst_n;
  logic [7:0] d_host;
  logic       d_host_oe;
  logic [7:0] d_dev;
  logic       d_dev_oe;
  logic [7:0] d;
  // Pulled-up data bus; device wins only if both drive (a host fault)
  assign d = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);
  modport dev  (input ce_n, wr_n, rd_n, blink_mem_select_n, addr,
                disp_rst_n, d, output d_dev, d_dev_oe);
  modport host (output ce_n, wr_n, rd_n, blink_mem_select_n, addr,
                disp_rst_n, d_host, d_host_oe, input d);
endinterface : ldc_bus_if

/* rtl/ldc_dev_end.sv */
// Display controller end: pin decode, control word, clear, reset,
// self test sequencing and flash/blink timing.
// Assumes pins arrive asynchronously; display tick derived from core_clk.
// Notes on behaviour
// - Control word written at ce,wr low, 4=1,3=0.
// - Control word read drives its contents on data.
// - Test shows checkerboard, then inverse, ~2s each.
// - Host makes no access during self test.
// - Self test lasts 262,144 display clock periods.
// - Test end: blanks, control zero except pass.
// - Clear bit fills 20 hex, clears flash.
// - Clear completes within three display clocks.
// - Host makes no access during clear.
// - Clear bit returns to zero by itself.
// - Reset pin clears memories, control, counters; here glyph RAM and glyph index keep their contents.
// - Reset lasts three display clocks; no access.
// - Strobes stay high while reset held.
// - Host resets display at power-up.
// - Shared clock, common reset release keep sync.
// - Character write stores code at selected digit.
// - Glyph index write, then seven row writes.
// - Bits 2-0 brightness; 111 blanks display.
// - Flash enable flashes flagged digits, clock/28672.
// - Blink enable blinks all, overrides flash.
// - Bit 6 starts test; bit 5 reads pass.
`include "ldc_params.svh"
module ldc_dev_end #(
  parameter int unsigned TICK_CYC   = `LDC_TICK_CYC,
  parameter int unsigned TEST_TICKS = `LDC_TEST_TICKS,
  parameter int unsigned PAT_TICKS  = `LDC_PAT_TICKS
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Pin side
  ldc_bus_if.dev          bus,
  // Display scan side
  input  wire logic [2:0] scan_digit,
  input  wire logic [2:0] scan_row,
  output logic      [7:0] scan_code,
  output logic      [4:0] scan_dots,
  output logic      [7:0] digit_on,
  output logic      [2:0] brightness,
  output logic      [1:0] test_pattern,
  output logic            busy
);
  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [17:0] pin_s1;
  logic [17:0] pin_s2;
  // Two stages; only pin_s2 feeds logic
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1 <= `LDC_PIN_IDLE;
      pin_s2 <= `LDC_PIN_IDLE;
    end
    else
    begin
      pin_s1 <= {bus.disp_rst_n, bus.ce_n, bus.wr_n, bus.rd_n,
                 bus.blink_mem_select_n, bus.addr, bus.d};
      pin_s2 <= pin_s1;
    end
  end

  logic       pin_rst_n;
  logic       addr_bit4;
  logic       addr_bit3;
  logic [2:0] sel_idx;
  logic [7:0] din;
  logic       wr_act;
  logic       rd_act;
  logic       wr_act_q;
  logic       wr_go;
  logic       sel_cw;
  logic       sel_char;
  logic       sel_gaddr;
  logic       sel_grow;
  logic       sel_flash;
  assign pin_rst_n = pin_s2[17];
  assign addr_bit4 = pin_s2[12];
  assign addr_bit3 = pin_s2[11];
  assign sel_idx   = pin_s2[10:8];
  assign din       = pin_s2[7:0];
  // Strobe decode; a read and write together select nothing
  assign wr_act    = ~pin_s2[16] & ~pin_s2[15] & pin_s2[14];
  assign rd_act    = ~pin_s2[16] & ~pin_s2[14] & pin_s2[15];
  assign sel_flash = ~pin_s2[13];
  assign sel_cw    = pin_s2[13] & addr_bit4 & ~addr_bit3;
  assign sel_char  = pin_s2[13] & addr_bit4 & addr_bit3;
  assign sel_gaddr = pin_s2[13] & ~addr_bit4 & ~addr_bit3;
  assign sel_grow  = pin_s2[13] & ~addr_bit4 & addr_bit3;

  // ---------------------------------------------------------------
  // Display tick and flash/blink timebase
  // ---------------------------------------------------------------
  logic [15:0] div;
  logic [15:0] next_div;
  logic [15:0] bcnt;
  logic [15:0] next_bcnt;
  logic        phase;
  logic        next_phase;
  logic        tick;
  assign tick = pin_rst_n && (div == 16'(TICK_CYC - 1));
  // Held at zero under reset so several displays restart in step
  always_comb
  begin
    next_div   = tick ? 16'h0000 : div + 16'h0001;
    next_bcnt  = bcnt;
    next_phase = phase;
    if (tick)
    begin
      // Half period of clock/28672 counted in ticks
      if (bcnt == 16'(`LDC_BLINK_DIV / 2 - 1))
      begin
        next_bcnt  = 16'h0000;
        next_phase = ~phase;
      end
      else
        next_bcnt = bcnt + 16'h0001;
    end
    if (!pin_rst_n)
    begin
      next_div   = 16'h0000;
      next_bcnt  = 16'h0000;
      next_phase = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div   <= 16'h0000;
      bcnt  <= 16'h0000;
      phase <= 1'b0;
    end
    else
    begin
      div   <= next_div;
      bcnt  <= next_bcnt;
      phase <= next_phase;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and control word
  // ---------------------------------------------------------------
  ldc_pkg::ldc_dev_state_t state;
  ldc_pkg::ldc_dev_state_t next_state;
  logic [31:0] tcnt;
  logic [31:0] next_tcnt;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic        pass;
  logic        next_pass;
  logic [3:0]  gaddr;
  logic [3:0]  next_gaddr;
  logic        mem_blank;

  assign wr_go = wr_act & ~wr_act_q & (state == ldc_pkg::DEV_IDLE);
  // Writes outside idle are dropped, reads are still answered; the host must wait them out
  always_comb
  begin
    next_state = state;
    next_tcnt  = tick ? tcnt + 32'h1 : tcnt;
    next_ctrl  = ctrl;
    next_pass  = pass;
    next_gaddr = gaddr;
    mem_blank  = 1'b0;
    case (state)
      ldc_pkg::DEV_RESET:
        if (tick && tcnt == 32'(`LDC_RST_TICKS - 1))
        begin
          next_state = ldc_pkg::DEV_IDLE;
          next_tcnt  = 32'h0;
        end
      ldc_pkg::DEV_IDLE:
      begin
        next_tcnt = 32'h0;
        if (wr_go && sel_cw)
        begin
          next_ctrl = din;
          if (din[`LDC_CW_TEST])
          begin
            next_state = ldc_pkg::DEV_TEST;
            next_pass  = 1'b0;
          end
          else if (din[`LDC_CW_CLEAR])
            next_state = ldc_pkg::DEV_CLEAR;
        end
        if (wr_go && sel_gaddr)
          next_gaddr = din[3:0];
      end
      ldc_pkg::DEV_CLEAR:
        if (tick && tcnt == 32'(`LDC_CLR_TICKS - 1))
        begin
          mem_blank                = 1'b1;
          next_ctrl[`LDC_CW_CLEAR] = 1'b0;
          next_state               = ldc_pkg::DEV_IDLE;
        end
      ldc_pkg::DEV_TEST:
      begin
        // Checksum routine has no ROM here, so it always passes
        if (tick && tcnt == 32'(TEST_TICKS - 2 * PAT_TICKS - 1))
          next_pass = 1'b1;
        if (tick && tcnt == 32'(TEST_TICKS - 1))
        begin
          mem_blank  = 1'b1;
          next_ctrl  = `LDC_CW_RESET;
          next_gaddr = `LDC_GLYPH_END;
          next_state = ldc_pkg::DEV_IDLE;
        end
      end
      default:
        next_state = ldc_pkg::DEV_RESET;
    endcase
    if (!pin_rst_n)
    begin
      next_state = ldc_pkg::DEV_RESET;
      next_tcnt  = 32'h0;
      next_ctrl  = `LDC_CW_RESET;
      next_pass  = 1'b0;
      mem_blank  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state    <= ldc_pkg::DEV_RESET;
      tcnt     <= 32'h0;
      ctrl     <= `LDC_CW_RESET;
      pass     <= 1'b0;
      gaddr    <= 4'h0;
      wr_act_q <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      tcnt     <= next_tcnt;
      ctrl     <= next_ctrl;
      pass     <= next_pass;
      gaddr    <= next_gaddr;
      wr_act_q <= wr_act;
    end
  end

  // ---------------------------------------------------------------
  // Character, flash and glyph memories
  // ---------------------------------------------------------------
  logic [7:0] char_mem [8];
  logic [7:0] flash;
  logic [4:0] glyph_ram [128];
  logic [7:0] next_digit_on;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_digit
      // Per digit store; blanking wins over a same-cycle write
      always_ff @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          char_mem[gi] <= `LDC_BLANK_CODE;
          flash[gi]    <= 1'b0;
        end
        else if (mem_blank)
        begin
          char_mem[gi] <= `LDC_BLANK_CODE;
          flash[gi]    <= 1'b0;
        end
        else if (wr_go && sel_idx == 3'(gi))
        begin
          if (sel_char)
            char_mem[gi] <= din;
          if (sel_flash)
            flash[gi] <= din[0];
        end
      end
      // Blink overrides flash; level 111 blanks everything
      always_comb
      begin
        if (ctrl[2:0] == `LDC_BLANK_LEVEL)
          next_digit_on[gi] = 1'b0;
        else if (state == ldc_pkg::DEV_TEST)
          next_digit_on[gi] = 1'b1;
        else if (ctrl[`LDC_CW_BLINK])
          next_digit_on[gi] = phase;
        else if (ctrl[`LDC_CW_FLASH] && flash[gi])
          next_digit_on[gi] = phase;
        else
          next_digit_on[gi] = 1'b1;
      end
    end
  endgenerate

  // Glyph rows; row address 111 does not exist and is dropped
  always_ff @(posedge core_clk)
  begin
    if (wr_go && sel_grow && sel_idx != 3'h7)
      glyph_ram[{gaddr, sel_idx}] <= din[4:0];
  end

  // ---------------------------------------------------------------
  // Read data and display outputs
  // ---------------------------------------------------------------
  logic [7:0] next_dout;
  logic [1:0] next_pat;
  always_comb
  begin
    next_dout = 8'h00;
    if (sel_flash)
      next_dout = {7'h00, flash[sel_idx]};
    else if (sel_cw)
      next_dout = {ctrl[7:6], pass, ctrl[4:0]};
    else if (sel_char)
      next_dout = char_mem[sel_idx];
    else if (sel_gaddr)
      next_dout = {4'h0, gaddr};
    else if (sel_idx != 3'h7)
      next_dout = {3'h0, glyph_ram[{gaddr, sel_idx}]};
    next_pat = 2'h0;
    if (state == ldc_pkg::DEV_TEST)
    begin
      if (tcnt >= 32'(TEST_TICKS - PAT_TICKS))
        next_pat = 2'h2;
      else if (tcnt >= 32'(TEST_TICKS - 2 * PAT_TICKS))
        next_pat = 2'h1;
    end
  end

  assign bus.d_dev_oe = rd_act;
  assign busy         = (state != ldc_pkg::DEV_IDLE);
  assign brightness   = ctrl[2:0];

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.d_dev    <= 8'h00;
      scan_code    <= 8'h00;
      scan_dots    <= 5'h00;
      digit_on     <= 8'h00;
      test_pattern <= 2'h0;
    end
    else
    begin
      bus.d_dev    <= next_dout;
      scan_code    <= char_mem[scan_digit];
      // Bit 7 picks a user glyph; ROM fonts are not held here
      scan_dots    <= char_mem[scan_digit][7]
                      ? glyph_ram[{char_mem[scan_digit][3:0], scan_row}]
                      : 5'h00;
      digit_on     <= next_digit_on;
      test_pattern <= next_pat;
    end
  end
endmodule : ldc_dev_end

/* rtl/ldc_host_end.sv */
// Host end: turns user commands into paced parallel bus cycles and
// waits out reset, clear and self test before the next access.
// Assumes a device on the same pins, clocked from a shared source.
`include "ldc_params.svh"
module ldc_host_end #(
  parameter int unsigned TICK_CYC   = `LDC_TICK_CYC,
  parameter int unsigned TEST_TICKS = `LDC_TEST_TICKS
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Pin side
  ldc_bus_if.host         bus,
  // Command port
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic       cmd_flash,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       disp_reset_req,
  // Read answer
  output logic            rsp_valid,
  output logic      [7:0] rsp_rdata
);
  // ---------------------------------------------------------------
  // Read data synchroniser
  // ---------------------------------------------------------------
  logic [7:0] d_s1;
  logic [7:0] d_s2;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      d_s1 <= 8'hff;
      d_s2 <= 8'hff;
    end
    else
    begin
      d_s1 <= bus.d;
      d_s2 <= d_s1;
    end
  end

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  ldc_pkg::ldc_host_state_t state;
  ldc_pkg::ldc_host_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        wr;
  logic        next_wr;
  logic        fl_n;
  logic        next_fl_n;
  logic [4:0]  addr;
  logic [4:0]  next_addr;
  logic [7:0]  dat;
  logic [7:0]  next_dat;
  logic        next_rsp_valid;
  logic [7:0]  next_rsp_rdata;
  logic        cw_hit;

  assign cmd_ready = (state == ldc_pkg::H_IDLE) && !disp_reset_req;
  assign cw_hit    = fl_n && addr[4] && !addr[3];

  // Waits are set so the device is idle again before the next cycle
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt - 32'h1;
    next_wr        = wr;
    next_fl_n      = fl_n;
    next_addr      = addr;
    next_dat       = dat;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    case (state)
      ldc_pkg::H_RST:
        if (cnt == 32'h0)
        begin
          next_state = ldc_pkg::H_WAIT;
          next_cnt   = 32'(`LDC_RST_TICKS * TICK_CYC + `LDC_MARGIN_CYC);
        end
      ldc_pkg::H_WAIT:
        if (cnt == 32'h0)
          next_state = ldc_pkg::H_IDLE;
      ldc_pkg::H_IDLE:
      begin
        next_cnt = 32'(`LDC_SETUP_CYC - 1);
        if (disp_reset_req)
        begin
          next_state = ldc_pkg::H_RST;
          next_cnt   = 32'(`LDC_RST_LOW_CYC - 1);
        end
        else if (cmd_valid)
        begin
          next_state = ldc_pkg::H_SETUP;
          next_wr    = cmd_write;
          next_fl_n  = ~cmd_flash;
          next_addr  = cmd_addr;
          next_dat   = cmd_wdata;
        end
      end
      ldc_pkg::H_SETUP:
        if (cnt == 32'h0)
        begin
          next_state = ldc_pkg::H_STROBE;
          next_cnt   = 32'(`LDC_STROBE_CYC - 1);
        end
      ldc_pkg::H_STROBE:
        if (cnt == 32'h0)
        begin
          next_state     = ldc_pkg::H_HOLD;
          next_cnt       = 32'(`LDC_HOLD_CYC - 1);
          next_rsp_valid = !wr;
          next_rsp_rdata = d_s2;
        end
      ldc_pkg::H_HOLD:
        if (cnt == 32'h0)
        begin
          next_state = ldc_pkg::H_WAIT;
          next_cnt   = 32'h0;
          if (wr && cw_hit && dat[`LDC_CW_TEST])
            next_cnt = 32'(TEST_TICKS * TICK_CYC + `LDC_MARGIN_CYC);
          else if (wr && cw_hit && dat[`LDC_CW_CLEAR])
            next_cnt = 32'(`LDC_CLR_TICKS * TICK_CYC + `LDC_MARGIN_CYC);
        end
      default:
        next_state = ldc_pkg::H_RST;
    endcase
  end

  // Power-up starts in reset with the pin driven low
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= ldc_pkg::H_RST;
      cnt       <= 32'(`LDC_RST_LOW_CYC - 1);
      wr        <= 1'b0;
      fl_n      <= 1'b1;
      addr      <= 5'h00;
      dat       <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      wr        <= next_wr;
      fl_n      <= next_fl_n;
      addr      <= next_addr;
      dat       <= next_dat;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers, all from flops
  // ---------------------------------------------------------------
  logic strobe_ns;
  logic cyc_ns;
  assign cyc_ns    = (next_state == ldc_pkg::H_SETUP) ||
                     (next_state == ldc_pkg::H_STROBE) ||
                     (next_state == ldc_pkg::H_HOLD);
  assign strobe_ns = (next_state == ldc_pkg::H_STROBE);
  // Strobes held high whenever the reset pin is low
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.disp_rst_n         <= 1'b0;
      bus.ce_n               <= 1'b1;
      bus.wr_n               <= 1'b1;
      bus.rd_n               <= 1'b1;
      bus.blink_mem_select_n <= 1'b1;
      bus.addr               <= 5'h00;
      bus.d_host             <= 8'h00;
      bus.d_host_oe          <= 1'b0;
    end
    else
    begin
      // One release edge for all displays sharing this pin
      bus.disp_rst_n         <= (next_state != ldc_pkg::H_RST);
      bus.ce_n               <= !cyc_ns;
      bus.wr_n               <= !(strobe_ns && next_wr);
      bus.rd_n               <= !(strobe_ns && !next_wr);
      bus.blink_mem_select_n <= next_fl_n;
      bus.addr               <= next_addr;
      bus.d_host             <= next_dat;
      bus.d_host_oe          <= cyc_ns && next_wr;
    end
  end
endmodule : ldc_host_end

/* sim/ldc_monitor.sv */
// Pin checker for the bus between host end and device end.
// Assumes one core_clk domain; placed beside the bus interface.
module ldc_monitor #(
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Bus pins
  input wire logic       ce_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [4:0] addr,
  input wire logic       disp_rst_n,
  input wire logic       d_host_oe,
  input wire logic       d_dev_oe
);
  logic [15:0] since;
  logic [15:0] next_since;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Cycles since the reset pin rose; saturates so it cannot wrap
  always_comb
    next_since = !disp_rst_n ? 16'h0 : since + {15'h0, since != 16'hffff};
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      since <= 16'h0;
    else
      since <= next_since;
  // Pin relations
  a_reset_quiet: assert property (
    since < 3 * TICK_CYC |-> ce_n) else $error("access too soon");
  a_rst_idle: assert property (
    !disp_rst_n |-> wr_n && rd_n) else $error("strobe in reset");
  a_strobe_excl: assert property (
    wr_n || rd_n) else $error("both strobes low");
  a_write_len: assert property (
    $fell(wr_n) |-> !wr_n [*8] ##1 wr_n) else $error("strobe length");
  a_write_setup: assert property (
    $fell(wr_n) |-> !$past(ce_n, 2) && d_host_oe) else $error("setup");
  a_addr_held: assert property (
    !ce_n && !$fell(ce_n) |-> $stable(addr)) else $error("address moved");
  a_read_drive: assert property (
    $fell(rd_n) && !ce_n |-> ##[1:3] d_dev_oe) else $error("no answer");
  a_drive_cause: assert property (
    d_dev_oe |-> !($past(rd_n) && $past(rd_n, 2) && $past(rd_n, 3)))
    else $error("unasked drive");
  // Main scenarios reached
  c_write: cover property ($rose(wr_n));
  c_read: cover property ($fell(rd_n) ##[1:3] d_dev_oe);
  c_reset: cover property ($rose(disp_rst_n));
endmodule : ldc_monitor

/* sim/tb_led_matrix_display_ctrl_port.sv */
// Bench: host end and device end joined over one bus interface.
// Assumes short tick and test counts to keep the run short.
module tb_led_matrix_display_ctrl_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TK = 4;
  localparam int unsigned TT = 64;
  // Bench-driven inputs, valued at time zero
  logic       core_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
  logic       cmd_write = 1'b0, cmd_flash = 1'b0, disp_reset_req = 1'b0;
  logic [4:0] cmd_addr = 5'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] scan_digit = 3'h0, scan_row = 3'h0;
  // Design outputs and counters
  logic       cmd_ready, rsp_valid, busy;
  logic [7:0] rsp_rdata, scan_code, digit_on;
  logic [4:0] scan_dots;
  logic [2:0] brightness;
  logic [1:0] test_pattern;
  int         mismatches = 0, total_checks = 0;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  ldc_bus_if bus ();
  ldc_dev_end #(.TICK_CYC(TK), .TEST_TICKS(TT), .PAT_TICKS(16))
    ldc_dev_end_i (.core_clk, .rstn, .bus, .scan_digit, .scan_row,
    .scan_code, .scan_dots, .digit_on, .brightness, .test_pattern, .busy);
  ldc_host_end #(.TICK_CYC(TK), .TEST_TICKS(TT))
    ldc_host_end_i (.core_clk, .rstn, .bus, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_flash, .cmd_addr, .cmd_wdata, .disp_reset_req,
    .rsp_valid, .rsp_rdata);
  ldc_monitor #(.TICK_CYC(TK))
    ldc_monitor_i (.core_clk, .rstn, .ce_n(bus.ce_n), .wr_n(bus.wr_n),
    .rd_n(bus.rd_n), .addr(bus.addr), .disp_rst_n(bus.disp_rst_n),
    .d_host_oe(bus.d_host_oe), .d_dev_oe(bus.d_dev_oe));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  // One bounded wait step; a hang counts as a mismatch
  task automatic step(inout int n);
    @(negedge core_clk);
    if (++n > 3000)
    begin
      chk(8'h01, 8'h00);
      give_verdict();
    end
  endtask : step
  // Host command raised after a rising edge, dropped at the take edge
  task automatic cmd(input logic w, f, input logic [4:0] a,
                     input logic [7:0] v);
    int n = 0;
    do step(n); while (cmd_ready !== 1'b1);
    @(posedge core_clk);
    {cmd_valid, cmd_write, cmd_flash} <= {1'b1, w, f};
    {cmd_addr, cmd_wdata} <= {a, v};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic rd(input logic f, input logic [4:0] a, input logic [7:0] e);
    int n = 0;
    cmd(1'b0, f, a, 8'h00);
    do step(n); while (rsp_valid !== 1'b1);
    chk(rsp_rdata, e);
  endtask : rd
  // Scan one digit row; waits out the pin synchroniser first
  task automatic see(input logic [2:0] g, r, input logic [7:0] c,
                     input logic [4:0] o);
    @(posedge core_clk);
    {scan_digit, scan_row} <= {g, r};
    repeat (10) @(negedge core_clk);
    chk(scan_code, c);
    chk({3'h0, scan_dots}, {3'h0, o});
  endtask : see
  // Busy length in cycles, and test patterns seen in order
  task automatic span(input int lo, hi, output int p);
    int n = 0;
    p = 0;
    do step(n); while (busy !== 1'b1);
    n = 0;
    while (busy === 1'b1)
    begin
      step(n);
      p += (test_pattern === 2'(p + 1)) ? 1 : 0;
    end
    chk(8'(n >= lo && n <= hi), 8'h01);
  endtask : span
  task automatic s_ctrl();
    rd(1'b0, 5'h10, 8'h00);
    cmd(1'b1, 1'b0, 5'h13, 8'h1b);
    rd(1'b0, 5'h17, 8'h1b);
    chk({5'h0, brightness}, 8'h03);
    // Level 111, written with blink and flash clear, must switch every digit off
    cmd(1'b1, 1'b0, 5'h10, 8'h07);
    rd(1'b0, 5'h10, 8'h07);
    chk(digit_on, 8'h00);
  endtask : s_ctrl
  task automatic s_glyph();
    logic [34:0] g = {5'h0e, 5'h11, 5'h11, 5'h1f, 5'h11, 5'h11, 5'h11};
    cmd(1'b1, 1'b0, 5'h18, 8'h53);
    cmd(1'b1, 1'b0, 5'h00, 8'hf5);
    for (int r = 0; r < 7; r++)
      cmd(1'b1, 1'b0, {2'b01, 3'(r)}, {3'h0, g[34-5*r -: 5]});
    cmd(1'b1, 1'b0, 5'h1a, 8'h85);
    see(3'h0, 3'h0, 8'h53, 5'h00);
    for (int r = 0; r < 7; r++)
      see(3'h2, 3'(r), 8'h85, g[34-5*r -: 5]);
  endtask : s_glyph
  task automatic s_clear();
    int p;
    cmd(1'b1, 1'b1, 5'h03, 8'h01);
    rd(1'b1, 5'h03, 8'h01);
    // Flash bit set but flash disabled: every digit stays lit
    cmd(1'b1, 1'b0, 5'h10, 8'h03);
    rd(1'b0, 5'h10, 8'h03);
    chk(digit_on, 8'hff);
    cmd(1'b1, 1'b0, 5'h10, 8'h83);
    span(1, 3 * TK + 2, p);
    rd(1'b0, 5'h10, 8'h03);
    rd(1'b1, 5'h03, 8'h00);
    see(3'h2, 3'h0, 8'h20, 5'h00);
  endtask : s_clear
  task automatic s_test();
    int p;
    cmd(1'b1, 1'b0, 5'h1c, 8'h41);
    cmd(1'b1, 1'b1, 5'h05, 8'h01);
    cmd(1'b1, 1'b0, 5'h10, 8'h40);
    span((TT - 1) * TK, TT * TK + 2, p);
    chk(8'(p), 8'h02);
    rd(1'b0, 5'h10, 8'h20);
    see(3'h4, 3'h0, 8'h20, 5'h00);
    rd(1'b1, 5'h05, 8'h00);
    rd(1'b0, 5'h00, 8'h0f);
  endtask : s_test
  // Mid-run pin reset; request is dropped at the edge it is taken
  task automatic s_reset();
    int n = 0;
    cmd(1'b1, 1'b0, 5'h10, 8'h05);
    cmd(1'b1, 1'b0, 5'h19, 8'h48);
    cmd(1'b1, 1'b1, 5'h01, 8'h01);
    do step(n); while (cmd_ready !== 1'b1);
    @(posedge core_clk);
    disp_reset_req <= 1'b1;
    @(posedge core_clk);
    disp_reset_req <= 1'b0;
    rd(1'b0, 5'h10, 8'h00);
    rd(1'b1, 5'h01, 8'h00);
    see(3'h1, 3'h0, 8'h20, 5'h00);
    chk(digit_on, 8'hff);
  endtask : s_reset
  // Main sequence after two cycles of reset
  initial
  begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    s_ctrl();
    s_glyph();
    s_clear();
    s_test();
    s_reset();
    give_verdict();
  end
endmodule : tb_led_matrix_display_ctrl_port
